// file: design/hbs_cfg.svh
// Purpose: Address map and timing constants of the host byte stacker port
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef HBS_CFG_SVH
`define HBS_CFG_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define HBS_ADDR_W          7
`define HBS_RXQ_BASE        7'h60
`define HBS_TXQ_BASE        7'h70
`define HBS_CYCLE_TIMER_OFS 7'h14
`define HBS_PHY_ACCESS_OFS  7'h24

// ----------------------------------------------------------------------
// Size codes, ordered {width_or_size_low, protocol_or_size_high}
// ----------------------------------------------------------------------
`define HBS_SIZE_4B         2'b00
`define HBS_SIZE_2B         2'b01
`define HBS_SIZE_1B         2'b10
`define HBS_SIZE_16B        2'b11

// ----------------------------------------------------------------------
// Beat counts and timing
// ----------------------------------------------------------------------
`define HBS_BEATS_4B        8'h02
`define HBS_BEATS_2B        8'h01
`define HBS_BEATS_16B       8'h08
`define HBS_ACK_MIN_CYC     2

`endif

// file: design/hbs_core_access.sv
// Purpose: Core-side agent that performs one access per crossed request
// Assumes: Request fields are held stable by the bus side while in flight
// Notes:   Runs on mclk
`timescale 1ns/100ps
module hbs_core_access (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               req_pulse,
  input  wire logic               req_write,
  input  wire hbs_pkg::hbs_target_t req_target,
  input  wire logic [6:0]         req_addr,
  input  wire logic               req_word,
  input  wire logic [15:0]        req_wdata,
  input  wire logic               acc_done,
  input  wire logic [15:0]        acc_rdata,
  input  wire logic               event_in,
  output logic                    acc_valid,
  output logic                    acc_write,
  output hbs_pkg::hbs_target_t    acc_target,
  output logic [6:0]              acc_addr,
  output logic                    acc_word,
  output logic [15:0]             acc_wdata,
  output logic [15:0]             rdata_out,
  output logic                    done_tgl,
  output logic                    host_irq_n
);
  import hbs_pkg::*;

  logic        valid_reg,  valid_next;
  logic        busy_reg,   busy_next;
  logic        write_reg,  write_next;
  hbs_target_t target_reg, target_next;
  logic [6:0]  addr_reg,   addr_next;
  logic        word_reg,   word_next;
  logic [15:0] wdata_reg,  wdata_next;
  logic [15:0] rdata_reg,  rdata_next;
  logic        tgl_reg,    tgl_next;
  logic        irq_n_reg,  irq_n_next;

  always_comb begin
    valid_next  = 1'b0;
    busy_next   = busy_reg;
    write_next  = write_reg;
    target_next = target_reg;
    addr_next   = addr_reg;
    word_next   = word_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    tgl_next    = tgl_reg;
    irq_n_next  = ~event_in;
    if (req_pulse && !busy_reg) begin
      valid_next  = 1'b1;
      busy_next   = 1'b1;
      write_next  = req_write;
      target_next = req_target;
      addr_next   = req_addr;
      word_next   = req_word;
      wdata_next  = req_wdata;
    end else if (busy_reg && acc_done) begin
      busy_next = 1'b0;
      tgl_next  = ~tgl_reg;
      if (!write_reg) begin
        rdata_next = acc_rdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      valid_reg  <= 1'b0;
      busy_reg   <= 1'b0;
      write_reg  <= 1'b0;
      target_reg <= TGT_CFG;
      addr_reg   <= 7'h00;
      word_reg   <= 1'b0;
      wdata_reg  <= 16'h0000;
      rdata_reg  <= 16'h0000;
      tgl_reg    <= 1'b0;
      irq_n_reg  <= 1'b1;
    end else begin
      valid_reg  <= valid_next;
      busy_reg   <= busy_next;
      write_reg  <= write_next;
      target_reg <= target_next;
      addr_reg   <= addr_next;
      word_reg   <= word_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      tgl_reg    <= tgl_next;
      irq_n_reg  <= irq_n_next;
    end
  end

  assign acc_valid  = valid_reg;
  assign acc_write  = write_reg;
  assign acc_target = target_reg;
  assign acc_addr   = addr_reg;
  assign acc_word   = word_reg;
  assign acc_wdata  = wdata_reg;
  assign rdata_out  = rdata_reg;
  assign done_tgl   = tgl_reg;
  assign host_irq_n = irq_n_reg;
endmodule // hbs_core_access

// file: design/hbs_host_port.sv
// Purpose: Host processor bus port with fixed, handshake and burst modes
// Assumes: Host pins are synchronous to host_bus_clk
// Notes:   Every beat crosses to mclk and back by toggle handshake
`timescale 1ns/100ps
`include "hbs_cfg.svh"

// Overview of operation
// - Burst select low: size pins pick 16/8-bit, fixed timing or handshake.
// - Burst select high: codes 00, 01, 11 give 2, 1, 8 word transfers.
// - Single-byte size code is not supported in burst operation.
// - Reads only from config or receive queue; writes only config or transmit.
// - Port is a pure target; every cycle starts from the host.
// - Cycle timer and physical access registers refuse handshake, unaligned or single-word burst access.
// - Seven address lines and an 8- or 16-bit two-way data bus.
// - Line 0 of every bus group is the most significant bit.
// - Select and acknowledge handshake lets bus and core clocks run apart.
// - Events reach the host through an interrupt output.
// - Handshake: data driven, acknowledge low until select rises, then release.
// - Fixed timing: n select cycles give n acknowledge pulses after two cycles.
// - Transfer error pulses low one cycle on mode change or other error.
// - Burst operation: one acknowledge per 16-bit word, all lines used.
module hbs_host_port #(
  parameter int CNT_W = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 host_bus_clk,
  input  wire logic                 host_cycle_select_n,
  input  wire logic                 write_not_read,
  input  wire logic [0:6]           host_address_in,
  input  wire logic [0:15]          host_data_in,
  input  wire logic                 width_or_size_low,
  input  wire logic                 protocol_or_size_high,
  input  wire logic                 burst_host_select,
  input  wire logic                 acc_done,
  input  wire logic [15:0]          acc_rdata,
  input  wire logic                 event_in,
  output logic [0:15]               host_data_out,
  output logic                      host_data_oe_n,
  output logic                      cycle_acknowledge_out_n,
  output logic                      transfer_error_out_n,
  output logic                      acc_valid,
  output logic                      acc_write,
  output hbs_pkg::hbs_target_t      acc_target,
  output logic [6:0]                acc_addr,
  output logic                      acc_word,
  output logic [15:0]               acc_wdata,
  output logic                      host_irq_n
);
  import hbs_pkg::*;

  // --------------------------------------------------------------------
  // Bus side state
  // --------------------------------------------------------------------
  hbs_state_t       st_reg,       st_next;
  logic [2:0]       mode_reg,     mode_next;
  logic             wr_reg,       wr_next;
  logic [6:0]       addr_reg,     addr_next;
  hbs_target_t      tgt_reg,      tgt_next;
  logic [CNT_W-1:0] pend_reg,     pend_next;
  logic [CNT_W-1:0] done_cnt_reg, done_cnt_next;
  logic             req_tgl_reg,  req_tgl_next;
  logic             inflight_reg, inflight_next;
  logic [15:0]      wdata_reg,    wdata_next;
  logic [0:15]      dout_reg,     dout_next;
  logic             oe_n_reg,     oe_n_next;
  logic             ack_n_reg,    ack_n_next;
  logic             tea_n_reg,    tea_n_next;

  logic             sel_low;
  logic [2:0]       mode_now;
  logic [6:0]       addr_now;
  logic [15:0]      din;
  hbs_target_t      tgt_now;
  logic             now_burst;
  logic             now_hs;
  logic             err_now;
  logic             reg_burst;
  logic             reg_hs;
  logic             reg_byte;
  logic             reg_fixed;
  logic [CNT_W-1:0] beats_now;
  logic             done_pulse;
  logic             req_pulse_m;
  logic             done_tgl_m;
  logic [15:0]      rdata_m;

  // --------------------------------------------------------------------
  // Pin decode
  // --------------------------------------------------------------------
  assign sel_low   = ~host_cycle_select_n;
  assign mode_now  = {burst_host_select, width_or_size_low, protocol_or_size_high};
  assign addr_now  = host_address_in;
  assign din       = host_data_in;
  assign now_burst = mode_now[2];
  assign now_hs    = !mode_now[2] && mode_now[0];
  assign reg_burst = mode_reg[2];
  assign reg_hs    = !mode_reg[2] && mode_reg[0];
  assign reg_byte  = !mode_reg[2] && mode_reg[1];
  assign reg_fixed = !mode_reg[2] && !mode_reg[0];

  always_comb begin
    if (addr_now >= `HBS_TXQ_BASE) begin
      tgt_now = TGT_TXQ;
    end else if (addr_now >= `HBS_RXQ_BASE) begin
      tgt_now = TGT_RXQ;
    end else begin
      tgt_now = TGT_CFG;
    end
  end

  always_comb begin
    case (mode_now[1:0])
      `HBS_SIZE_4B:  beats_now = CNT_W'(`HBS_BEATS_4B);
      `HBS_SIZE_2B:  beats_now = CNT_W'(`HBS_BEATS_2B);
      `HBS_SIZE_16B: beats_now = CNT_W'(`HBS_BEATS_16B);
      default:       beats_now = '0;
    endcase
  end

  // --------------------------------------------------------------------
  // Access checks at the start of a cycle
  // --------------------------------------------------------------------
  always_comb begin
    err_now = 1'b0;
    if (now_burst && mode_now[1:0] == `HBS_SIZE_1B) begin
      err_now = 1'b1;
    end
    if ((!write_not_read && tgt_now == TGT_TXQ) ||
        (write_not_read && tgt_now == TGT_RXQ)) begin
      err_now = 1'b1;
    end
    if (tgt_now == TGT_CFG &&
        (addr_now[6:2] == `HBS_CYCLE_TIMER_OFS >> 2 ||
         addr_now[6:2] == `HBS_PHY_ACCESS_OFS >> 2) &&
        (now_hs || addr_now[1:0] != 2'b00 ||
         (now_burst && mode_now[1:0] == `HBS_SIZE_2B))) begin
      err_now = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Bus side sequencer
  // --------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    mode_next     = mode_reg;
    wr_next       = wr_reg;
    addr_next     = addr_reg;
    tgt_next      = tgt_reg;
    pend_next     = pend_reg;
    done_cnt_next = done_cnt_reg;
    req_tgl_next  = req_tgl_reg;
    inflight_next = inflight_reg;
    wdata_next    = wdata_reg;
    dout_next     = dout_reg;
    oe_n_next     = oe_n_reg;
    ack_n_next    = 1'b1;
    tea_n_next    = 1'b1;
    if (done_pulse) begin
      inflight_next = 1'b0;
    end
    // Each further select cycle in fixed timing adds one beat
    if (reg_fixed && sel_low && st_reg != ST_IDLE && st_reg != ST_ABORT) begin
      pend_next = pend_reg + CNT_W'(1);
    end
    case (st_reg)
      ST_IDLE: begin
        oe_n_next = 1'b1;
        if (sel_low) begin
          mode_next     = mode_now;
          wr_next       = write_not_read;
          addr_next     = addr_now;
          tgt_next      = tgt_now;
          done_cnt_next = '0;
          pend_next     = now_burst ? beats_now : CNT_W'(1);
          if (err_now) begin
            tea_n_next = 1'b0;
            st_next    = ST_ABORT;
          end else begin
            st_next = ST_LAUNCH;
          end
        end
      end
      ST_LAUNCH: begin
        // Data sampled one cycle after the address, as burst hosts need
        wdata_next    = reg_byte ? {8'h00, din[7:0]} : din;
        req_tgl_next  = ~req_tgl_reg;
        inflight_next = 1'b1;
        st_next       = ST_BUSY;
      end
      ST_BUSY: begin
        if (done_pulse) begin
          if (!wr_reg) begin
            dout_next = reg_byte ? {8'h00, rdata_m[7:0]} : rdata_m;
            oe_n_next = 1'b0;
          end
          ack_n_next    = 1'b0;
          done_cnt_next = done_cnt_reg + CNT_W'(1);
          st_next       = reg_hs ? ST_HOLD : ST_ACK;
        end
      end
      ST_ACK: begin
        if (tgt_reg == TGT_CFG) begin
          addr_next = addr_reg + ((reg_byte) ? 7'h01 : 7'h02);
        end
        if (pend_next != done_cnt_reg) begin
          st_next = ST_LAUNCH;
        end else begin
          oe_n_next = 1'b1;
          st_next   = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (sel_low) begin
          ack_n_next = 1'b0;
        end else begin
          oe_n_next = 1'b1;
          st_next   = ST_IDLE;
        end
      end
      ST_ABORT: begin
        oe_n_next = 1'b1;
        if (!sel_low && !inflight_next) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    // Size pins moving mid-cycle abandon the access
    if (st_reg != ST_IDLE && st_reg != ST_ABORT && mode_now != mode_reg) begin
      tea_n_next = 1'b0;
      ack_n_next = 1'b1;
      oe_n_next  = 1'b1;
      st_next    = ST_ABORT;
    end
  end

  always_ff @(posedge host_bus_clk or posedge rst) begin
    if (rst) begin
      st_reg       <= ST_IDLE;
      mode_reg     <= 3'h0;
      wr_reg       <= 1'b0;
      addr_reg     <= 7'h00;
      tgt_reg      <= TGT_CFG;
      pend_reg     <= '0;
      done_cnt_reg <= '0;
      req_tgl_reg  <= 1'b0;
      inflight_reg <= 1'b0;
      wdata_reg    <= 16'h0000;
      dout_reg     <= 16'h0000;
      oe_n_reg     <= 1'b1;
      ack_n_reg    <= 1'b1;
      tea_n_reg    <= 1'b1;
    end else begin
      st_reg       <= st_next;
      mode_reg     <= mode_next;
      wr_reg       <= wr_next;
      addr_reg     <= addr_next;
      tgt_reg      <= tgt_next;
      pend_reg     <= pend_next;
      done_cnt_reg <= done_cnt_next;
      req_tgl_reg  <= req_tgl_next;
      inflight_reg <= inflight_next;
      wdata_reg    <= wdata_next;
      dout_reg     <= dout_next;
      oe_n_reg     <= oe_n_next;
      ack_n_reg    <= ack_n_next;
      tea_n_reg    <= tea_n_next;
    end
  end

  assign host_data_out           = dout_reg;
  assign host_data_oe_n          = oe_n_reg;
  assign cycle_acknowledge_out_n = ack_n_reg;
  assign transfer_error_out_n    = tea_n_reg;

  // --------------------------------------------------------------------
  // Clock crossings
  // --------------------------------------------------------------------
  hbs_toggle_sync u_req_sync (
    .clk    (mclk),
    .rst    (rst),
    .tgl_in (req_tgl_reg),
    .pulse  (req_pulse_m)
  );

  hbs_toggle_sync u_done_sync (
    .clk    (host_bus_clk),
    .rst    (rst),
    .tgl_in (done_tgl_m),
    .pulse  (done_pulse)
  );

  // --------------------------------------------------------------------
  // Core side agent
  // --------------------------------------------------------------------
  hbs_core_access u_core (
    .mclk       (mclk),
    .rst        (rst),
    .req_pulse  (req_pulse_m),
    .req_write  (wr_reg),
    .req_target (tgt_reg),
    .req_addr   (addr_reg),
    .req_word   (~reg_byte),
    .req_wdata  (wdata_reg),
    .acc_done   (acc_done),
    .acc_rdata  (acc_rdata),
    .event_in   (event_in),
    .acc_valid  (acc_valid),
    .acc_write  (acc_write),
    .acc_target (acc_target),
    .acc_addr   (acc_addr),
    .acc_word   (acc_word),
    .acc_wdata  (acc_wdata),
    .rdata_out  (rdata_m),
    .done_tgl   (done_tgl_m),
    .host_irq_n (host_irq_n)
  );
endmodule // hbs_host_port

// file: design/hbs_pkg.sv
// Purpose: Types shared by the host byte stacker port
// Assumes: Nothing
// Notes:   Constants live in hbs_cfg.svh
package hbs_pkg;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_LAUNCH = 6'b00_0010,
    ST_BUSY   = 6'b00_0100,
    ST_ACK    = 6'b00_1000,
    ST_HOLD   = 6'b01_0000,
    ST_ABORT  = 6'b10_0000
  } hbs_state_t;

  typedef enum logic [1:0] {
    TGT_CFG = 2'b00,
    TGT_RXQ = 2'b01,
    TGT_TXQ = 2'b10
  } hbs_target_t;

endpackage

// file: design/hbs_toggle_sync.sv
// Purpose: Carries an event across clocks as a toggle, gives a pulse
// Assumes: Source toggles at most once per round trip
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module hbs_toggle_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tgl_in,
  output logic      pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  always_comb begin
    meta_next = tgl_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign pulse = sync_reg ^ last_reg;
endmodule // hbs_toggle_sync

// file: test/hbs_host_model.sv
// Purpose: Host bus master model for the host byte stacker port
// Assumes: Pins change just after a rising host_bus_clk edge
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/100ps
module hbs_host_model (
  input  wire logic        clk,
  input  wire logic        ack_n,
  input  wire logic        tea_n,
  input  wire logic [0:15] dout,
  output logic             sel_n,
  output logic             wnr,
  output logic [0:6]       adr,
  output logic [0:15]      dat,
  output logic             wsl,
  output logic             psh,
  output logic             bhs
);
  // Cycle of a transfer at which the width pin flips, 0 for never
  int flip_at = 0;

  initial begin
    sel_n = 1'b1;
    wnr   = 1'b0;
    adr   = 7'h00;
    dat   = 16'h0000;
    {bhs, wsl, psh} = 3'b000;
  end

  // One cycle; handshake holds select until acknowledge or error
  task automatic xfer(input logic bs, input logic [1:0] sz, input logic wr,
                      input logic [6:0] a, input logic [15:0] d, input int nsel,
                      output int acks, output int teas, output logic [15:0] rd);
    bit hs;
    bit pa;
    hs   = !bs && sz[0];
    pa   = 1'b1;
    acks = 0;
    teas = 0;
    rd   = 16'h0000;
    @(posedge clk);
    {bhs, wsl, psh} <= {bs, sz};
    wnr   <= wr;
    adr   <= a;
    dat   <= d;
    sel_n <= 1'b0;
    for (int t = 1; t <= 120; t++) begin
      @(posedge clk);
      if (t == 1) adr <= ~a;
      if (t == flip_at) wsl <= ~wsl;
      if (!ack_n && pa) acks++;
      if (!ack_n) rd = dout;
      if (!tea_n) teas++;
      pa = ack_n;
      if (hs ? (!ack_n || !tea_n) : t >= nsel) sel_n <= 1'b1;
    end
    dat <= ~d;
  endtask
endmodule // hbs_host_model

// file: test/hbs_host_port_chk.sv
// Purpose: Port-level assertions of the host byte stacker port
// Assumes: Bound to every instance of hbs_host_port
// Notes:   Host bus and core clock domains checked apart
`timescale 1ns/100ps
module hbs_host_port_chk #(
  parameter int CNT_W = 8
) (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 host_bus_clk,
  input wire logic                 host_cycle_select_n,
  input wire logic                 write_not_read,
  input wire logic [0:6]           host_address_in,
  input wire logic [0:15]          host_data_in,
  input wire logic                 width_or_size_low,
  input wire logic                 protocol_or_size_high,
  input wire logic                 burst_host_select,
  input wire logic                 acc_done,
  input wire logic [15:0]          acc_rdata,
  input wire logic                 event_in,
  input wire logic [0:15]          host_data_out,
  input wire logic                 host_data_oe_n,
  input wire logic                 cycle_acknowledge_out_n,
  input wire logic                 transfer_error_out_n,
  input wire logic                 acc_valid,
  input wire logic                 acc_write,
  input wire hbs_pkg::hbs_target_t acc_target,
  input wire logic [6:0]           acc_addr,
  input wire logic                 acc_word,
  input wire logic [15:0]          acc_wdata,
  input wire logic                 host_irq_n
);
  a_tea_one_cycle: assert property (@(posedge host_bus_clk) disable iff (rst)
    $fell(transfer_error_out_n) |=> transfer_error_out_n) else $error("long error pulse");
  a_ack_not_early: assert property (@(posedge host_bus_clk) disable iff (rst)
    $fell(host_cycle_select_n) |-> cycle_acknowledge_out_n [*2]) else $error("early ack");
  a_hs_ack_hold: assert property (@(posedge host_bus_clk) disable iff (rst)
    !burst_host_select && protocol_or_size_high && !host_cycle_select_n
    && !cycle_acknowledge_out_n |=> !cycle_acknowledge_out_n) else $error("ack dropped");
  a_hs_release: assert property (@(posedge host_bus_clk) disable iff (rst)
    !burst_host_select && protocol_or_size_high && host_cycle_select_n
    && !cycle_acknowledge_out_n |=> cycle_acknowledge_out_n && host_data_oe_n)
    else $error("no release");
  a_read_drives: assert property (@(posedge host_bus_clk) disable iff (rst)
    !cycle_acknowledge_out_n && !write_not_read |-> !host_data_oe_n) else $error("not driven");
  a_tea_no_ack: assert property (@(posedge host_bus_clk) disable iff (rst)
    !transfer_error_out_n |-> cycle_acknowledge_out_n) else $error("ack with error");
  a_byte_burst_refused: assert property (@(posedge host_bus_clk) disable iff (rst)
    burst_host_select && width_or_size_low && !protocol_or_size_high
    && $fell(host_cycle_select_n) |-> ##[1:60] !transfer_error_out_n) else $error("no refusal");
  a_irq_follow: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> host_irq_n == !$past(event_in)) else $error("irq mismatch");
  a_valid_pulse: assert property (@(posedge mclk) disable iff (rst)
    acc_valid |=> !acc_valid) else $error("request not a pulse");
endmodule // hbs_host_port_chk

bind hbs_host_port hbs_host_port_chk #(.CNT_W(CNT_W)) u_chk (.mclk, .rst, .host_bus_clk,
  .host_cycle_select_n, .write_not_read, .host_address_in, .host_data_in, .width_or_size_low,
  .protocol_or_size_high, .burst_host_select, .acc_done, .acc_rdata, .event_in, .host_data_out,
  .host_data_oe_n, .cycle_acknowledge_out_n, .transfer_error_out_n, .acc_valid, .acc_write,
  .acc_target, .acc_addr, .acc_word, .acc_wdata, .host_irq_n);

// file: test/tb_hbs_host_port.sv
// Purpose: Self-checking bench of the host byte stacker port
// Assumes: Core access answered one mclk after each request
// Notes:   Host bus clock of 6 ns runs apart from the 4 ns core clock
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_hbs_host_port;
  import hbs_pkg::*;
  logic        mclk, rst, hclk, sel_n, wnr, wsl, psh, bhs, acc_done, event_in;
  logic        oe_n, ack_n, tea_n, acc_valid, acc_write, acc_word, irq_n;
  logic [0:6]  adr;
  logic [0:15] dat, dout;
  logic [15:0] acc_rdata, acc_wdata, rd;
  logic [6:0]  acc_addr;
  hbs_target_t acc_target;
  logic [10:0] acc_q[$];
  logic [15:0] wd_q[$];
  int          failures, n_compared, cyc, acks, teas;

  function automatic logic [15:0] rdf(input logic [6:0] a);
    return {2'b10, a, ~a};
  endfunction

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    hclk = 1'b0;
    #1.3;
    forever #3 hclk = ~hclk;
  end

  hbs_host_port DUT (.mclk(mclk), .rst(rst), .host_bus_clk(hclk), .host_cycle_select_n(sel_n),
    .write_not_read(wnr), .host_address_in(adr), .host_data_in(dat), .width_or_size_low(wsl),
    .protocol_or_size_high(psh), .burst_host_select(bhs), .acc_done(acc_done),
    .acc_rdata(acc_rdata), .event_in(event_in), .host_data_out(dout), .host_data_oe_n(oe_n),
    .cycle_acknowledge_out_n(ack_n), .transfer_error_out_n(tea_n), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_target(acc_target), .acc_addr(acc_addr), .acc_word(acc_word),
    .acc_wdata(acc_wdata), .host_irq_n(irq_n));
  hbs_host_model u_host (.clk(hclk), .ack_n(ack_n), .tea_n(tea_n), .dout(dout), .sel_n(sel_n),
    .wnr(wnr), .adr(adr), .dat(dat), .wsl(wsl), .psh(psh), .bhs(bhs));

  // Core side answers each request and logs it
  always @(posedge mclk) begin
    acc_done  <= acc_valid;
    acc_rdata <= rdf(acc_addr);
    if (acc_valid === 1'b1) begin
      acc_q.push_back({acc_write, acc_target, acc_addr, acc_word});
      wd_q.push_back(acc_wdata);
    end
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic run(input logic bs, input logic [1:0] sz, input logic wr,
                     input logic [6:0] a, input logic [15:0] d, input int n);
    acc_q.delete();
    wd_q.delete();
    u_host.xfer(bs, sz, wr, a, d, n, acks, teas, rd);
  endtask

  task automatic t_handshake();
    run(1'b0, 2'b01, 1'b0, 7'h10, 16'h0000, 1);
    `CHK(acks, 1)
    `CHK(rd, rdf(7'h10))
    `CHK(acc_q[0], {1'b0, TGT_CFG, 7'h10, 1'b1})
    run(1'b0, 2'b11, 1'b0, 7'h11, 16'h0000, 1);
    `CHK(rd, rdf(7'h11) & 16'h00ff)
    `CHK(acc_q[0], {1'b0, TGT_CFG, 7'h11, 1'b0})
  endtask

  task automatic t_fixed();
    run(1'b0, 2'b00, 1'b1, 7'h20, 16'ha55a, 2);
    `CHK(acks, 2)
    `CHK(acc_q[1], {1'b1, TGT_CFG, 7'h22, 1'b1})
    `CHK(wd_q[0], 16'ha55a)
    run(1'b0, 2'b10, 1'b1, 7'h31, 16'h005a, 2);
    `CHK(acks, 2)
    `CHK(acc_q[1], {1'b1, TGT_CFG, 7'h32, 1'b0})
    `CHK(wd_q[0], 16'h005a)
  endtask

  task automatic t_bursts();
    run(1'b1, 2'b11, 1'b0, 7'h60, 16'h0000, 1);
    `CHK(acks, 8)
    `CHK(acc_q[7], {1'b0, TGT_RXQ, 7'h60, 1'b1})
    `CHK(rd, rdf(7'h60))
    run(1'b1, 2'b00, 1'b0, 7'h14, 16'h0000, 1);
    `CHK(acks, 2)
    `CHK(acc_q[1], {1'b0, TGT_CFG, 7'h16, 1'b1})
    run(1'b1, 2'b01, 1'b1, 7'h70, 16'h1234, 1);
    `CHK(acks, 1)
    `CHK(acc_q[0], {1'b1, TGT_TXQ, 7'h70, 1'b1})
    `CHK(wd_q[0], 16'h1234)
  endtask

  task automatic t_refusals();
    logic [10:0] tbl [4];
    tbl = '{{3'b110, 1'b0, 7'h10}, {3'b001, 1'b1, 7'h60},
            {3'b001, 1'b0, 7'h70}, {3'b001, 1'b0, 7'h16}};
    foreach (tbl[i]) begin
      run(tbl[i][10], tbl[i][9:8], tbl[i][7], tbl[i][6:0], 16'h0f0f, 1);
      `CHK(teas, 1)
      `CHK(acks, 0)
      `CHK(acc_q.size(), 0)
    end
    u_host.flip_at = 2;
    run(1'b0, 2'b01, 1'b0, 7'h10, 16'h0000, 1);
    u_host.flip_at = 0;
    `CHK(teas, 1)
    `CHK(acks, 0)
    `CHK(acc_q.size(), 1)
  endtask

  task automatic t_irq();
    @(posedge mclk);
    event_in <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(irq_n, 1'b0)
    event_in <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(irq_n, 1'b1)
  endtask

  initial begin
    rst        = 1'b1;
    event_in   = 1'b0;
    acc_done   = 1'b0;
    acc_rdata  = 16'h0000;
    failures   = 0;
    n_compared = 0;
    cyc        = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_handshake();
    t_fixed();
    t_bursts();
    t_refusals();
    t_irq();
    finish_test();
  end
endmodule // tb_hbs_host_port
